//--- sud_socket.sv
// socket command engine: registers, commands, send, IGMP and raw filter
`timescale 1ns/10ps
`default_nettype none
module sud_socket
  import sud_pkg::*;
#(
  parameter int unsigned REPORT_PERIOD = sud_pkg::REPORT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  output logic irq,
  output logic tx_req,
  output logic [1:0] tx_kind,
  output logic tx_igmp_v2,
  output logic tx_raw,
  output logic [7:0] tx_proto,
  output logic [47:0] tx_dst_mac,
  output logic [31:0] tx_dst_ip,
  output logic [15:0] tx_dst_port,
  output logic [15:0] tx_src_port,
  output logic [15:0] tx_ptr,
  output logic [15:0] tx_len,
  input wire logic tx_done,
  input wire logic tx_arp_timeout,
  input wire logic rx_valid,
  input wire logic [7:0] rx_proto,
  output logic rx_to_socket,
  output logic rx_to_builtin,
  output logic rx_drop
);
  import sud_pkg::*;

  // ----------------------------------------
  // host registers
  // ----------------------------------------
  logic [7:0] socket_config_reg;
  logic [7:0] socket_command_reg;
  logic [7:0] socket_event_flags;
  logic [7:0] socket_state_reg;
  logic [7:0] ip_protocol_number;
  logic global_event_flags;
  logic event_mask_reg;
  logic [7:0] addr_bytes [ADDR_BYTES];
  logic [15:0] tx_write_pointer;
  logic [15:0] tx_read_pointer;

  sud_eng_e eng;
  logic mcast_open;
  logic [47:0] grp_mac;
  logic [31:0] grp_ip;
  logic [15:0] grp_port;
  logic [15:0] send_end;
  logic report_tick;

  logic [47:0] reg_mac;
  logic [31:0] reg_ip;
  logic [15:0] reg_dport;
  logic [15:0] reg_sport;
  logic [3:0] protocol_select_field;
  logic multi_sel;
  logic igmp_v2_sel;
  logic sock_open;
  logic cmd_wr;
  logic ev_send_done_flag;
  logic ev_timeout;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  assign protocol_select_field = socket_config_reg[3:0];
  assign multi_sel = socket_config_reg[CFG_MULTI_BIT];
  assign igmp_v2_sel = socket_config_reg[CFG_IGMPV2_BIT];
  assign sock_open = socket_state_reg != ST_CLOSED;
  assign cmd_wr = wr_en && (addr == OFF_CMD);
  assign reg_mac = {addr_bytes[AB_MAC], addr_bytes[AB_MAC+1],
                    addr_bytes[AB_MAC+2], addr_bytes[AB_MAC+3],
                    addr_bytes[AB_MAC+4], addr_bytes[AB_MAC+5]};
  assign reg_ip = {addr_bytes[AB_IP], addr_bytes[AB_IP+1],
                   addr_bytes[AB_IP+2], addr_bytes[AB_IP+3]};
  assign reg_dport = {addr_bytes[AB_DPORT], addr_bytes[AB_DPORT+1]};
  assign reg_sport = {addr_bytes[AB_SPORT], addr_bytes[AB_SPORT+1]};

  // ----------------------------------------
  // host-written configuration
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      socket_config_reg <= RST_BYTE;
      ip_protocol_number <= RST_BYTE;
      event_mask_reg <= 1'b0;
      tx_write_pointer <= RST_PTR;
    end else if (wr_en) begin
      case (addr)
        OFF_CONFIG: socket_config_reg <= wdata;
        OFF_PROTO: ip_protocol_number <= wdata;
        OFF_MASK: event_mask_reg <= wdata[0];
        OFF_TXWR_HI: tx_write_pointer[15:8] <= wdata;
        OFF_TXWR_LO: tx_write_pointer[7:0] <= wdata;
        default: ;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ADDR_BYTES; gi++) begin : g_addr
      always_ff @(posedge clk) begin
        if (rst) begin
          addr_bytes[gi] <= RST_BYTE;
        end else if (wr_en && addr == OFF_ADDR_FIRST + 5'(gi)) begin
          addr_bytes[gi] <= wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // command engine
  // ----------------------------------------
  sud_report_timer #(
    .PERIOD(REPORT_PERIOD)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .run(mcast_open),
    .tick(report_tick)
  );

  assign ev_send_done_flag = (eng == SUD_SEND) && tx_done;
  assign ev_timeout = (eng == SUD_SEND) && tx_arp_timeout && !tx_done;

  always_ff @(posedge clk) begin
    if (rst) begin
      eng <= SUD_IDLE;
      socket_command_reg <= CMD_NONE;
      socket_state_reg <= ST_CLOSED;
      mcast_open <= 1'b0;
      grp_mac <= 48'h0;
      grp_ip <= 32'h0;
      grp_port <= 16'h0;
      send_end <= RST_PTR;
      tx_read_pointer <= RST_PTR;
      tx_req <= 1'b0;
      tx_kind <= TXK_DATA;
      tx_igmp_v2 <= 1'b0;
      tx_raw <= 1'b0;
      tx_proto <= RST_BYTE;
      tx_dst_mac <= 48'h0;
      tx_dst_ip <= 32'h0;
      tx_dst_port <= 16'h0;
      tx_src_port <= 16'h0;
      tx_ptr <= RST_PTR;
      tx_len <= RST_PTR;
    end else begin
      tx_req <= 1'b0;
      // latch in any engine state, so a write during a report is kept
      if (cmd_wr && socket_command_reg == CMD_NONE) begin
        socket_command_reg <= wdata;
      end
      case (eng)
        SUD_IDLE: begin
          if (report_tick && mcast_open) begin
            tx_req <= 1'b1;
            tx_kind <= TXK_REPORT;
            tx_dst_mac <= grp_mac;
            tx_dst_ip <= grp_ip;
            tx_igmp_v2 <= igmp_v2_sel;
            tx_proto <= PROTO_IGMP;
            tx_raw <= 1'b0;
            eng <= SUD_REPORT;
          end else begin
            case (socket_command_reg)
              CMD_NONE: ;
              CMD_OPEN: begin
                socket_command_reg <= CMD_NONE;
                if (sock_open) begin
                  socket_command_reg <= CMD_NONE;
                end else if (protocol_select_field == MODE_UDP) begin
                  socket_state_reg <= ST_UDP;
                  grp_mac <= reg_mac;
                  grp_ip <= reg_ip;
                  grp_port <= reg_dport;
                  if (multi_sel) begin
                    mcast_open <= 1'b1;
                    socket_command_reg <= CMD_OPEN;
                    tx_req <= 1'b1;
                    tx_kind <= TXK_JOIN;
                    tx_igmp_v2 <= igmp_v2_sel;
                    tx_dst_mac <= reg_mac;
                    tx_dst_ip <= reg_ip;
                    tx_proto <= PROTO_IGMP;
                    tx_raw <= 1'b0;
                    eng <= SUD_JOIN;
                  end
                end else if (protocol_select_field == MODE_IPRAW &&
                             ip_protocol_number != PROTO_TCP &&
                             ip_protocol_number != PROTO_UDP) begin
                  socket_state_reg <= ST_IPRAW;
                end
              end
              CMD_CLOSE: begin
                if (mcast_open && igmp_v2_sel) begin
                  tx_req <= 1'b1;
                  tx_kind <= TXK_LEAVE;
                  tx_igmp_v2 <= 1'b1;
                  tx_dst_mac <= grp_mac;
                  tx_dst_ip <= grp_ip;
                  tx_proto <= PROTO_IGMP;
                  tx_raw <= 1'b0;
                  eng <= SUD_LEAVE;
                end else begin
                  socket_state_reg <= ST_CLOSED;
                  mcast_open <= 1'b0;
                  socket_command_reg <= CMD_NONE;
                end
              end
              CMD_SEND: begin
                if (!sock_open) begin
                  socket_command_reg <= CMD_NONE;
                end else begin
                  tx_req <= 1'b1;
                  tx_kind <= TXK_DATA;
                  tx_ptr <= tx_read_pointer;
                  tx_len <= tx_write_pointer - tx_read_pointer;
                  send_end <= tx_write_pointer;
                  tx_src_port <= reg_sport;
                  tx_raw <= socket_state_reg == ST_IPRAW;
                  tx_proto <= (socket_state_reg == ST_IPRAW) ?
                              ip_protocol_number : PROTO_UDP;
                  tx_dst_mac <= mcast_open ? grp_mac : reg_mac;
                  tx_dst_ip <= mcast_open ? grp_ip : reg_ip;
                  tx_dst_port <= mcast_open ? grp_port : reg_dport;
                  eng <= SUD_SEND;
                end
              end
              default: socket_command_reg <= CMD_NONE;
            endcase
          end
        end
        SUD_SEND: begin
          if (tx_done || tx_arp_timeout) begin
            tx_read_pointer <= send_end;
            socket_command_reg <= CMD_NONE;
            eng <= SUD_IDLE;
          end
        end
        SUD_JOIN, SUD_REPORT: begin
          if (tx_done) begin
            if (eng == SUD_JOIN) begin
              socket_command_reg <= CMD_NONE;
            end
            eng <= SUD_IDLE;
          end
        end
        SUD_LEAVE: begin
          if (tx_done) begin
            socket_state_reg <= ST_CLOSED;
            mcast_open <= 1'b0;
            socket_command_reg <= CMD_NONE;
            eng <= SUD_IDLE;
          end
        end
        default: eng <= SUD_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // event flags and interrupt
  // ----------------------------------------
  always_comb begin
    flag_set = 8'h00;
    flag_set[FLAG_SEND_DONE_FLAG_BIT] = ev_send_done_flag;
    flag_set[FLAG_TIMEOUT_BIT] = ev_timeout;
    flag_clr = (wr_en && addr == OFF_FLAGS) ? wdata : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      socket_event_flags <= RST_BYTE;
      global_event_flags <= 1'b0;
      irq <= 1'b0;
    end else begin
      // set wins over a same-cycle clear
      socket_event_flags <= (socket_event_flags & ~flag_clr) | flag_set;
      if (|flag_set) begin
        global_event_flags <= 1'b1;
      end else if (wr_en && addr == OFF_GFLAGS && wdata[0]) begin
        global_event_flags <= 1'b0;
      end
      irq <= global_event_flags && event_mask_reg;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= RST_BYTE;
    end else if (rd_en) begin
      rdata <= RST_BYTE;
      case (addr)
        OFF_CONFIG: rdata <= socket_config_reg;
        OFF_CMD: rdata <= socket_command_reg;
        OFF_FLAGS: rdata <= socket_event_flags;
        OFF_STATE: rdata <= socket_state_reg;
        OFF_PROTO: rdata <= ip_protocol_number;
        OFF_GFLAGS: rdata <= {7'h0, global_event_flags};
        OFF_MASK: rdata <= {7'h0, event_mask_reg};
        OFF_TXWR_HI: rdata <= tx_write_pointer[15:8];
        OFF_TXWR_LO: rdata <= tx_write_pointer[7:0];
        OFF_TXRD_HI: rdata <= tx_read_pointer[15:8];
        OFF_TXRD_LO: rdata <= tx_read_pointer[7:0];
        default: begin
          if (addr >= OFF_ADDR_FIRST && addr <= OFF_ADDR_LAST) begin
            rdata <= addr_bytes[4'(addr - OFF_ADDR_FIRST)];
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // receive steering
  // ----------------------------------------
  sud_rx_filter u_rx (
    .clk(clk),
    .rst(rst),
    .raw_open(socket_state_reg == ST_IPRAW),
    .raw_proto(ip_protocol_number),
    .rx_valid(rx_valid),
    .rx_proto(rx_proto),
    .rx_to_socket(rx_to_socket),
    .rx_to_builtin(rx_to_builtin),
    .rx_drop(rx_drop)
  );
endmodule // sud_socket
`default_nettype wire

//--- sud_pkg.sv
// shared constants and functional notes of the socket command engine
//
// Functional notes
// - command register reads zero again once a send has been carried out.
// - address-resolution timeout abandons the send and sets timeout, not send-done.
// - hardware sets send-done on completion; host clears it by writing one.
// - interrupt output asserts only for events enabled in the mask.
// - opening in multicast mode sends an IGMP join on its own.
// - closing a multicast socket sends an IGMP leave on its own when IGMP v2 is selected.
// - open multicast socket sends membership reports periodically.
// - built-in group handling covers IGMP versions 1 and 2 only.
// - UDP mode with multicast bit then open gives the datagram-open state.
// - multicast sends go to the group latched at open.
// - IP-raw socket carries the IP protocol selected by its number.
// - ICMP echo and IGMP v1/v2 handled without an IP-raw socket.
// - IP-raw open refuses the TCP and UDP protocol numbers.
// - open IP-raw socket only exchanges packets of its own protocol.
// - IP-raw mode code then open gives the IP-raw state, else host retries.
package sud_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [4:0] OFF_CONFIG = 5'h00;
  localparam logic [4:0] OFF_CMD = 5'h01;
  localparam logic [4:0] OFF_FLAGS = 5'h02;
  localparam logic [4:0] OFF_STATE = 5'h03;
  localparam logic [4:0] OFF_PROTO = 5'h04;
  localparam logic [4:0] OFF_GFLAGS = 5'h05;
  localparam logic [4:0] OFF_MASK = 5'h06;
  localparam logic [4:0] OFF_ADDR_FIRST = 5'h08;
  localparam logic [4:0] OFF_ADDR_LAST = 5'h15;
  localparam logic [4:0] OFF_TXWR_HI = 5'h16;
  localparam logic [4:0] OFF_TXWR_LO = 5'h17;
  localparam logic [4:0] OFF_TXRD_HI = 5'h18;
  localparam logic [4:0] OFF_TXRD_LO = 5'h19;
  localparam int ADDR_BYTES = 14;
  // byte positions inside the address block
  localparam int AB_MAC = 0;
  localparam int AB_IP = 6;
  localparam int AB_DPORT = 10;
  localparam int AB_SPORT = 12;

  // ----------------------------------------
  // fields and codes
  // ----------------------------------------
  localparam int CFG_MULTI_BIT = 7;
  localparam int CFG_IGMPV2_BIT = 5;
  localparam logic [3:0] MODE_UDP = 4'h2;
  localparam logic [3:0] MODE_IPRAW = 4'h3;
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_OPEN = 8'h01;
  localparam logic [7:0] CMD_CLOSE = 8'h10;
  localparam logic [7:0] CMD_SEND = 8'h20;
  localparam logic [7:0] ST_CLOSED = 8'h00;
  localparam logic [7:0] ST_UDP = 8'h22;
  localparam logic [7:0] ST_IPRAW = 8'h32;
  localparam int FLAG_SEND_DONE_FLAG_BIT = 4;
  localparam int FLAG_TIMEOUT_BIT = 3;
  localparam logic [7:0] PROTO_ICMP = 8'h01;
  localparam logic [7:0] PROTO_IGMP = 8'h02;
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PTR = 16'h0000;

  // ----------------------------------------
  // transmit kinds and timing
  // ----------------------------------------
  localparam logic [1:0] TXK_DATA = 2'h0;
  localparam logic [1:0] TXK_JOIN = 2'h1;
  localparam logic [1:0] TXK_LEAVE = 2'h2;
  localparam logic [1:0] TXK_REPORT = 2'h3;
  localparam int CLK_KHZ = 125000;
  localparam int REPORT_PERIOD_MS = 1000;
  localparam int REPORT_CYCLES = REPORT_PERIOD_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    SUD_IDLE = 3'b000,
    SUD_SEND = 3'b001,
    SUD_JOIN = 3'b011,
    SUD_REPORT = 3'b010,
    SUD_LEAVE = 3'b110
  } sud_eng_e;
endpackage

//--- sud_report_timer.sv
// periodic membership report tick
`timescale 1ns/10ps
`default_nettype none
module sud_report_timer #(
  parameter int unsigned PERIOD = 125000000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  logic [31:0] count;

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count == PERIOD - 1) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // sud_report_timer
`default_nettype wire

//--- sud_rx_filter.sv
// steers received IP packets to the raw socket or the built-in handler
`timescale 1ns/10ps
`default_nettype none
module sud_rx_filter
  import sud_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic raw_open,
  input wire logic [7:0] raw_proto,
  input wire logic rx_valid,
  input wire logic [7:0] rx_proto,
  output logic rx_to_socket,
  output logic rx_to_builtin,
  output logic rx_drop
);
  logic match;
  logic builtin;

  assign match = raw_open && (rx_proto == raw_proto);
  assign builtin = (rx_proto == PROTO_ICMP) || (rx_proto == PROTO_IGMP);

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_to_socket <= 1'b0;
      rx_to_builtin <= 1'b0;
      rx_drop <= 1'b0;
    end else begin
      rx_to_socket <= rx_valid && match;
      rx_to_builtin <= rx_valid && !match && builtin;
      rx_drop <= rx_valid && !match && !builtin;
    end
  end
endmodule // sud_rx_filter
`default_nettype wire

//--- sud_socket_properties.sv
// port assertions for the socket command engine
`timescale 1ns/10ps
`default_nettype none
module sud_socket_properties
  import sud_pkg::*;
#(
  parameter int unsigned REPORT_PERIOD = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic irq,
  input wire logic tx_req,
  input wire logic [1:0] tx_kind,
  input wire logic tx_raw,
  input wire logic [7:0] tx_proto,
  input wire logic tx_done,
  input wire logic tx_arp_timeout,
  input wire logic rx_valid,
  input wire logic [7:0] rx_proto,
  input wire logic rx_to_socket,
  input wire logic rx_to_builtin,
  input wire logic rx_drop
);
  logic mask_q;
  logic busy;
  logic [2:0] rxo;
  assign rxo = {rx_to_socket, rx_to_builtin, rx_drop};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) mask_q <= 1'b0;
    else if (wr_en && addr == OFF_MASK) mask_q <= wdata[0];
  end
  // one transmission in flight
  always_ff @(posedge clk) begin
    if (rst || tx_done || tx_arp_timeout) busy <= 1'b0;
    else if (tx_req) busy <= 1'b1;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_req_pulse: assert property (tx_req |=> !tx_req)
    else $error("transmit request longer than one cycle");
  chk_one_request: assert property (tx_req |-> !busy)
    else $error("transmit request while one is outstanding");
  chk_irq_mask: assert property (irq |-> $past(mask_q))
    else $error("interrupt raised while masked");
  chk_udp_proto: assert property (
    tx_req && tx_kind == TXK_DATA && !tx_raw |-> tx_proto == PROTO_UDP)
    else $error("datagram send without udp protocol");
  chk_igmp_proto: assert property (
    tx_req && tx_kind != TXK_DATA |-> tx_proto == PROTO_IGMP && !tx_raw)
    else $error("group message without igmp protocol");
  chk_raw_proto: assert property (
    tx_req && tx_raw |-> tx_proto != PROTO_TCP && tx_proto != PROTO_UDP)
    else $error("raw send with tcp or udp number");
  chk_rx_route: assert property (rx_valid |=> $onehot(rxo))
    else $error("received packet not steered exactly once");
  chk_rx_quiet: assert property (!rx_valid |=> rxo == 3'b000)
    else $error("steering pulse without a packet");
  chk_builtin_keep: assert property (
    rx_valid && (rx_proto == PROTO_ICMP || rx_proto == PROTO_IGMP)
    |=> !rx_drop)
    else $error("icmp or igmp packet dropped");
  chk_no_tcp_raw: assert property (
    rx_valid && (rx_proto == PROTO_TCP || rx_proto == PROTO_UDP)
    |=> !rx_to_socket)
    else $error("tcp or udp packet given to raw socket");
  cov_join: cover property (tx_req && tx_kind == TXK_JOIN);
  cov_leave: cover property (tx_req && tx_kind == TXK_LEAVE);
  cov_report: cover property (tx_req && tx_kind == TXK_REPORT);
  cov_raw_rx: cover property (rx_to_socket);
endmodule // sud_socket_properties

bind sud_socket sud_socket_properties #(.REPORT_PERIOD(REPORT_PERIOD)) u_chk (
  .clk, .rst, .addr, .wdata, .wr_en, .irq, .tx_req, .tx_kind, .tx_raw,
  .tx_proto, .tx_done, .tx_arp_timeout, .rx_valid, .rx_proto,
  .rx_to_socket, .rx_to_builtin, .rx_drop
);
`default_nettype wire

//--- sud_net_model.sv
// network side: answers each transmit request after a delay
`timescale 1ns/10ps
`default_nettype none
module sud_net_model
  import sud_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_req,
  input wire logic [1:0] tx_kind,
  input wire logic [3:0] delay,
  input wire logic arp_fail,
  output logic tx_done,
  output logic tx_arp_timeout
);
  logic [4:0] cnt;
  logic pend;
  logic fail;
  always_ff @(posedge clk) begin
    tx_done <= 1'b0;
    tx_arp_timeout <= 1'b0;
    if (rst) begin
      pend <= 1'b0;
      fail <= 1'b0;
      cnt <= 5'h00;
    end else if (tx_req) begin
      pend <= 1'b1;
      cnt <= {1'b0, delay};
      fail <= arp_fail && tx_kind == TXK_DATA;
    end else if (pend && cnt == 5'h00) begin
      pend <= 1'b0;
      tx_done <= !fail;
      tx_arp_timeout <= fail;
    end else if (pend) begin
      cnt <= cnt - 5'h01;
    end
  end
endmodule // sud_net_model
`default_nettype wire

//--- sud_socket_test.sv
// self-checking bench for the socket command engine
`timescale 1ns/10ps
`default_nettype none
module sud_socket_test;
  import sud_pkg::*;
  localparam int unsigned RP = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_proto = 8'h00;
  logic [3:0] delay = 4'h0;
  logic arp_fail = 1'b0;
  logic [7:0] rdata, tx_proto, d_proto, v;
  logic irq, tx_req, tx_igmp_v2, tx_raw, tx_done, tx_arp_timeout;
  logic rx_to_socket, rx_to_builtin, rx_drop, d_raw, mc_v2;
  logic [1:0] tx_kind;
  logic [47:0] tx_dst_mac, d_mac;
  logic [31:0] tx_dst_ip, d_ip;
  logic [15:0] tx_dst_port, tx_src_port, tx_ptr, tx_len, d_len;
  logic [15:0] d_port, d_sport, d_ptr;
  logic [15:0] wp = 16'h0040;
  logic [15:0] rp = 16'h0000;
  logic [111:0] grp = 112'h01005e01010b_e001010b_0fa0_0fa0;
  logic [7:0] ptab [4] = '{PROTO_TCP, PROTO_UDP, PROTO_ICMP, PROTO_IGMP};
  int n_kind [4] = '{0, 0, 0, 0};
  int n_fail = 0;
  int compares = 0;
  int seed = 63722;

  always #4 clk = ~clk;

  sud_socket #(.REPORT_PERIOD(RP)) uut (
    .clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq, .tx_req,
    .tx_kind, .tx_igmp_v2, .tx_raw, .tx_proto, .tx_dst_mac, .tx_dst_ip,
    .tx_dst_port, .tx_src_port, .tx_ptr, .tx_len, .tx_done,
    .tx_arp_timeout, .rx_valid, .rx_proto, .rx_to_socket, .rx_to_builtin,
    .rx_drop
  );
  sud_net_model net (
    .clk, .rst, .tx_req, .tx_kind, .delay, .arp_fail, .tx_done,
    .tx_arp_timeout
  );

  // ----------------------------------------
  // transmit monitor and tasks
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst && tx_req) begin
      n_kind[tx_kind] = n_kind[tx_kind] + 1;
      if (tx_kind == TXK_JOIN) mc_v2 = tx_igmp_v2;
      if (tx_kind == TXK_DATA) begin
        d_ip = tx_dst_ip;
        d_mac = tx_dst_mac;
        d_port = tx_dst_port;
        d_sport = tx_src_port;
        d_ptr = tx_ptr;
        d_len = tx_len;
        d_raw = tx_raw;
        d_proto = tx_proto;
      end
    end
  end
  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] exp_flags(input logic timed_out);
    exp_flags = 8'h00;
    exp_flags[timed_out ? FLAG_TIMEOUT_BIT : FLAG_SEND_DONE_FLAG_BIT] = 1'b1;
  endfunction
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [4:0] a,
                      input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    v = rdata;
    if (nm != "") chk(nm, {40'h0, e}, {40'h0, v});
  endtask
  task automatic cmd(input logic [7:0] c);
    int i;
    wr(OFF_CMD, c);
    for (i = 0; i < 200 && v !== CMD_NONE || i == 0; i++)
      rchk("", OFF_CMD, 8'h00);
    chk("cmd_clear", 48'h0, {40'h0, v});
  endtask
  task automatic setptr();
    wr(OFF_TXWR_HI, wp[15:8]);
    wr(OFF_TXWR_LO, wp[7:0]);
  endtask
  task automatic rx(input logic [7:0] p, input logic [2:0] e);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_proto <= p;
    @(posedge clk);
    rx_valid <= 1'b0;
    @(negedge clk);
    chk("rx_route", {45'h0, e}, {45'h0, rx_to_socket, rx_to_builtin,
        rx_drop});
  endtask
  task automatic grp_load(input logic [7:0] cfg);
    int i;
    for (i = 0; i < 14; i++)
      wr(OFF_ADDR_FIRST + 5'(i), grp[111 - 8 * i -: 8]);
    wr(OFF_CONFIG, cfg);
    cmd(CMD_OPEN);
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    n_fail++;
    $display("[ERR] watchdog exp done got hang");
    stop_test();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    int i, k;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rchk("state", OFF_STATE, ST_CLOSED);
    rchk("unmapped", 5'h1f, 8'h00);
    wr(OFF_TXRD_LO, 8'h5a);
    rchk("rd_ptr_ro", OFF_TXRD_LO, 8'h00);
    setptr();
    cmd(CMD_SEND);
    rchk("closed_send", OFF_TXRD_LO, 8'h00);
    chk("closed_req", 48'h0, 48'(n_kind[0]));
    $display("end closed_socket");
    wr(OFF_MASK, 8'h01);
    grp_load(8'ha2);
    rchk("mc_state", OFF_STATE, ST_UDP);
    chk("join", 48'h1, 48'(n_kind[1]));
    chk("join_v2", 48'h1, {47'h0, mc_v2});
    for (k = 0; k < 6; k++) begin
      wp = wp + 16'($random(seed) & 255) + 16'h0001;
      setptr();
      for (i = 6; i < 14; i++)
        wr(OFF_ADDR_FIRST + 5'(i), 8'($random(seed)));
      delay <= 4'($random(seed));
      arp_fail <= (k == 5);
      wr(OFF_MASK, {7'h0, k != 2});
      cmd(CMD_SEND);
      chk("len", 48'(wp - rp), 48'(d_len));
      chk("dst_ip", 48'h0000e001010b, 48'(d_ip));
      chk("dst_mac", 48'h01005e01010b, d_mac);
      chk("dst_port", 48'h0fa0, 48'(d_port));
      chk("tx_ptr", 48'(rp), 48'(d_ptr));
      rp = wp;
      rchk("flags", OFF_FLAGS, exp_flags(k == 5));
      chk("irq", 48'(k != 2), 48'(irq));
      wr(OFF_FLAGS, 8'hff);
      wr(OFF_GFLAGS, 8'h01);
      rchk("flags_clr", OFF_FLAGS, 8'h00);
      chk("irq_clr", 48'h0, 48'(irq));
    end
    arp_fail <= 1'b0;
    chk("reports", 48'h1, 48'(n_kind[3] > 0));
    cmd(CMD_CLOSE);
    chk("leave", 48'h1, 48'(n_kind[2]));
    rchk("mc_closed", OFF_STATE, ST_CLOSED);
    i = n_kind[3];
    repeat (3 * RP) @(posedge clk);
    chk("no_report", 48'(i), 48'(n_kind[3]));
    grp_load(8'h82);
    chk("join_v1", 48'h0, {47'h0, mc_v2});
    cmd(CMD_CLOSE);
    chk("v1_leave", 48'h1, 48'(n_kind[2]));
    $display("end multicast");
    for (k = 0; k < 4; k++) begin
      wr(OFF_PROTO, ptab[k]);
      wr(OFF_CONFIG, {4'h0, MODE_IPRAW});
      cmd(CMD_OPEN);
      rchk("raw_state", OFF_STATE, k < 2 ? ST_CLOSED : ST_IPRAW);
      if (k >= 2) begin
        rx(ptab[k], 3'b100);
        rx(ptab[5 - k], 3'b010);
        rx(8'h59, 3'b001);
        wp = wp + 16'h0010;
        setptr();
        cmd(CMD_SEND);
        chk("raw_proto", {40'h0, ptab[k]}, {40'h0, d_proto});
        chk("raw_flag", 48'h1, {47'h0, d_raw});
        chk("src_port", 48'h0fa0, 48'(d_sport));
        wr(OFF_FLAGS, 8'hff);
        wr(OFF_GFLAGS, 8'h01);
        cmd(CMD_CLOSE);
      end
    end
    rx(PROTO_ICMP, 3'b010);
    $display("end ip_raw");
    stop_test();
  end
endmodule // sud_socket_test
`default_nettype wire
